// >>> rtl/sbst_regs.svh
`ifndef SBST_REGS_SVH
`define SBST_REGS_SVH

`define SBST_IR_W         3
`define SBST_IR_EXTEST    3'h0
`define SBST_IR_IDCODE    3'h1
`define SBST_IR_SAMPLE_Z  3'h2
`define SBST_IR_SAMPLE    3'h4
`define SBST_IR_BYPASS    3'h7
`define SBST_IR_CAPTURE   3'h1
`define SBST_ID_W         32
`define SBST_BSR_OE_CELL  47
`define SBST_BYPASS_CAP   1'b0

`define SBST_ST_TLR       4'h0
`define SBST_ST_RTI       4'h1
`define SBST_ST_SEL_DR    4'h3
`define SBST_ST_CAP_DR    4'h2
`define SBST_ST_SHIFT_DR  4'h6
`define SBST_ST_EXIT1_DR  4'h7
`define SBST_ST_PAUSE_DR  4'h5
`define SBST_ST_EXIT2_DR  4'h4
`define SBST_ST_UPD_DR    4'hc
`define SBST_ST_SEL_IR    4'hd
`define SBST_ST_CAP_IR    4'hf
`define SBST_ST_SHIFT_IR  4'he
`define SBST_ST_EXIT1_IR  4'ha
`define SBST_ST_PAUSE_IR  4'hb
`define SBST_ST_EXIT2_IR  4'h9
`define SBST_ST_UPD_IR    4'h8

`endif

// >>> rtl/sbst_pkg.sv
`include "sbst_regs.svh"

package sbst_pkg;

  typedef enum logic [3:0] {
    SBST_TLR      = `SBST_ST_TLR,
    SBST_RTI      = `SBST_ST_RTI,
    SBST_SEL_DR   = `SBST_ST_SEL_DR,
    SBST_CAP_DR   = `SBST_ST_CAP_DR,
    SBST_SHIFT_DR = `SBST_ST_SHIFT_DR,
    SBST_EXIT1_DR = `SBST_ST_EXIT1_DR,
    SBST_PAUSE_DR = `SBST_ST_PAUSE_DR,
    SBST_EXIT2_DR = `SBST_ST_EXIT2_DR,
    SBST_UPD_DR   = `SBST_ST_UPD_DR,
    SBST_SEL_IR   = `SBST_ST_SEL_IR,
    SBST_CAP_IR   = `SBST_ST_CAP_IR,
    SBST_SHIFT_IR = `SBST_ST_SHIFT_IR,
    SBST_EXIT1_IR = `SBST_ST_EXIT1_IR,
    SBST_PAUSE_IR = `SBST_ST_PAUSE_IR,
    SBST_EXIT2_IR = `SBST_ST_EXIT2_IR,
    SBST_UPD_IR   = `SBST_ST_UPD_IR
  } sbst_state_t;

  typedef enum logic [1:0] {
    SBST_DR_BYPASS = 2'h0,
    SBST_DR_ID     = 2'h1,
    SBST_DR_BSR    = 2'h2
  } sbst_dr_sel_t;

endpackage

// >>> rtl/sbst_ctl_if.sv
interface sbst_ctl_if;
  logic                 rise;
  logic                 tms;
  sbst_pkg::sbst_state_t state;

  modport fsm (
    input  rise,
    input  tms,
    output state
  );

  modport dp (
    output rise,
    output tms,
    input  state
  );
endinterface

// >>> rtl/sbst_sync.sv
module sbst_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         ref_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] q_q;
  logic [W-1:0] q_d;

  always_comb begin
    meta_d = d_i;
    q_d    = meta_q;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= RST_VAL;
      q_q    <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      q_q    <= q_d;
    end
  end

  assign q_o = q_q;

endmodule

// >>> rtl/sbst_fsm.sv
module sbst_fsm (
  input  wire logic ref_clk_i,
  input  wire logic sys_rst_i,
  sbst_ctl_if.fsm   ctl
);

  sbst_pkg::sbst_state_t state_q;
  sbst_pkg::sbst_state_t state_d;
  sbst_pkg::sbst_state_t step;

  // Standard walk; from any state five high mode-select edges reach reset
  always_comb begin
    step = sbst_pkg::SBST_TLR;
    case (state_q)
      sbst_pkg::SBST_TLR:
        step = ctl.tms ? sbst_pkg::SBST_TLR : sbst_pkg::SBST_RTI;
      sbst_pkg::SBST_RTI:
        step = ctl.tms ? sbst_pkg::SBST_SEL_DR : sbst_pkg::SBST_RTI;
      sbst_pkg::SBST_SEL_DR:
        step = ctl.tms ? sbst_pkg::SBST_SEL_IR : sbst_pkg::SBST_CAP_DR;
      sbst_pkg::SBST_CAP_DR:
        step = ctl.tms ? sbst_pkg::SBST_EXIT1_DR : sbst_pkg::SBST_SHIFT_DR;
      sbst_pkg::SBST_SHIFT_DR:
        step = ctl.tms ? sbst_pkg::SBST_EXIT1_DR : sbst_pkg::SBST_SHIFT_DR;
      sbst_pkg::SBST_EXIT1_DR:
        step = ctl.tms ? sbst_pkg::SBST_UPD_DR : sbst_pkg::SBST_PAUSE_DR;
      sbst_pkg::SBST_PAUSE_DR:
        step = ctl.tms ? sbst_pkg::SBST_EXIT2_DR : sbst_pkg::SBST_PAUSE_DR;
      sbst_pkg::SBST_EXIT2_DR:
        step = ctl.tms ? sbst_pkg::SBST_UPD_DR : sbst_pkg::SBST_SHIFT_DR;
      sbst_pkg::SBST_UPD_DR:
        step = ctl.tms ? sbst_pkg::SBST_SEL_DR : sbst_pkg::SBST_RTI;
      sbst_pkg::SBST_SEL_IR:
        step = ctl.tms ? sbst_pkg::SBST_TLR : sbst_pkg::SBST_CAP_IR;
      sbst_pkg::SBST_CAP_IR:
        step = ctl.tms ? sbst_pkg::SBST_EXIT1_IR : sbst_pkg::SBST_SHIFT_IR;
      sbst_pkg::SBST_SHIFT_IR:
        step = ctl.tms ? sbst_pkg::SBST_EXIT1_IR : sbst_pkg::SBST_SHIFT_IR;
      sbst_pkg::SBST_EXIT1_IR:
        step = ctl.tms ? sbst_pkg::SBST_UPD_IR : sbst_pkg::SBST_PAUSE_IR;
      sbst_pkg::SBST_PAUSE_IR:
        step = ctl.tms ? sbst_pkg::SBST_EXIT2_IR : sbst_pkg::SBST_PAUSE_IR;
      sbst_pkg::SBST_EXIT2_IR:
        step = ctl.tms ? sbst_pkg::SBST_UPD_IR : sbst_pkg::SBST_SHIFT_IR;
      sbst_pkg::SBST_UPD_IR:
        step = ctl.tms ? sbst_pkg::SBST_SEL_DR : sbst_pkg::SBST_RTI;
      default:
        step = sbst_pkg::SBST_TLR;
    endcase
    state_d = ctl.rise ? step : state_q;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= sbst_pkg::SBST_TLR;
    end else begin
      state_q <= state_d;
    end
  end

  assign ctl.state = state_q;

endmodule

// >>> rtl/sbst_tap.sv
`include "sbst_regs.svh"

module sbst_tap #(
  parameter int              FUNC_PINS = 101,
  parameter int              NC_CELLS  = 8,
  // Arbitrary identification value; bit 0 kept high as scan chains expect
  parameter logic [31:0]     ID_CODE   = 32'h0aa5_5001
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic                          tck_i,
  input  wire logic                          tms_i,
  input  wire logic                          tdi_i,
  input  wire logic [FUNC_PINS-1:0]          ring_i,
  output logic                               tdo_o,
  output logic                               tdo_oe_o,
  output logic [FUNC_PINS+NC_CELLS-1:0]      bsr_pdata_o,
  output logic                               extest_o,
  output logic                               q_oe_o
);

  localparam int BSR_LEN = FUNC_PINS + NC_CELLS;
  localparam int IR_W    = `SBST_IR_W;
  localparam int ID_W    = `SBST_ID_W;
  localparam int OE_CELL = `SBST_BSR_OE_CELL;

  // Reset image of the update latches: only the output-enable cell is high
  localparam logic [BSR_LEN-1:0] UPD_RST =
    {{(BSR_LEN-1){1'b0}}, 1'b1} << OE_CELL;

  // Pin synchronisers; mode select and data inputs reset high like the pads' pull-ups, the test clock resets low
  logic                 tck_s;
  logic                 tms_s;
  logic                 tdi_s;
  logic [FUNC_PINS-1:0] ring_s;

  sbst_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_sync_tck (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (tck_i),
    .q_o       (tck_s)
  );

  sbst_sync #(
    .W       (2),
    .RST_VAL (2'h3)
  ) u_sync_ctl (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({tms_i, tdi_i}),
    .q_o       ({tms_s, tdi_s})
  );

  // The memory pins move fast against the test clock; a capture taken
  // while they toggle is not repeatable, the synchroniser only stops
  // metastability from spreading.
  sbst_sync #(
    .W       (FUNC_PINS),
    .RST_VAL ('0)
  ) u_sync_ring (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (ring_i),
    .q_o       (ring_s)
  );

  // Test clock edge detection
  logic tck_prev_q;
  logic tck_prev_d;
  logic tck_rise;
  logic tck_fall;

  always_comb begin
    tck_prev_d = tck_s;
    tck_rise   = tck_s & ~tck_prev_q;
    tck_fall   = ~tck_s & tck_prev_q;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_prev_d;
    end
  end

  // Controller
  sbst_ctl_if ctl ();

  assign ctl.rise = tck_rise;
  assign ctl.tms  = tms_s;

  sbst_fsm u_fsm (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .ctl       (ctl)
  );

  sbst_pkg::sbst_state_t state;
  assign state = ctl.state;

  // Scan and update registers
  logic [IR_W-1:0]    ir_sh_q;
  logic [IR_W-1:0]    ir_sh_d;
  logic [IR_W-1:0]    ir_q;
  logic [IR_W-1:0]    ir_d;
  logic               byp_q;
  logic               byp_d;
  logic [ID_W-1:0]    id_q;
  logic [ID_W-1:0]    id_d;
  logic [BSR_LEN-1:0] bsr_q;
  logic [BSR_LEN-1:0] bsr_d;
  logic [BSR_LEN-1:0] upd_q;
  logic [BSR_LEN-1:0] upd_d;
  logic               tdo_q;
  logic               tdo_d;
  logic               tdo_oe_q;
  logic               tdo_oe_d;

  sbst_pkg::sbst_dr_sel_t dr_sel;
  logic                   dr_lsb;
  logic                   bsr_inst;
  logic                   extest;
  logic                   sample_z;

  // Data register selection by the current instruction
  always_comb begin
    extest   = (ir_q == `SBST_IR_EXTEST);
    sample_z = (ir_q == `SBST_IR_SAMPLE_Z);
    bsr_inst = extest || sample_z || (ir_q == `SBST_IR_SAMPLE);
    case (ir_q)
      `SBST_IR_IDCODE:   dr_sel = sbst_pkg::SBST_DR_ID;
      `SBST_IR_EXTEST,
      `SBST_IR_SAMPLE_Z,
      `SBST_IR_SAMPLE:   dr_sel = sbst_pkg::SBST_DR_BSR;
      default:           dr_sel = sbst_pkg::SBST_DR_BYPASS;
    endcase
    case (dr_sel)
      sbst_pkg::SBST_DR_ID:  dr_lsb = id_q[0];
      sbst_pkg::SBST_DR_BSR: dr_lsb = bsr_q[0];
      default:               dr_lsb = byp_q;
    endcase
  end

  // Per-state strobes; captures and shifts on the rising edge of the test
  // clock, updates and the serial output on its fall
  logic cap_ir;
  logic shift_ir;
  logic cap_dr;
  logic shift_dr;
  logic upd_ir;
  logic upd_dr;
  logic in_reset;
  logic sel_byp;
  logic sel_id;
  logic sel_bsr;

  always_comb begin
    cap_ir   = 1'b0;
    shift_ir = 1'b0;
    cap_dr   = 1'b0;
    shift_dr = 1'b0;
    upd_ir   = 1'b0;
    upd_dr   = 1'b0;
    in_reset = 1'b0;
    case (state)
      sbst_pkg::SBST_CAP_IR:   cap_ir   = tck_rise;
      sbst_pkg::SBST_SHIFT_IR: shift_ir = tck_rise;
      sbst_pkg::SBST_CAP_DR:   cap_dr   = tck_rise;
      sbst_pkg::SBST_SHIFT_DR: shift_dr = tck_rise;
      sbst_pkg::SBST_UPD_IR:   upd_ir   = tck_fall;
      sbst_pkg::SBST_UPD_DR:   upd_dr   = tck_fall;
      // Reset state overrides everything; it only touches test logic
      sbst_pkg::SBST_TLR:      in_reset = 1'b1;
      default: begin
      end
    endcase
    sel_byp = (dr_sel == sbst_pkg::SBST_DR_BYPASS);
    sel_id  = (dr_sel == sbst_pkg::SBST_DR_ID);
    sel_bsr = bsr_inst;
  end

  // Instruction shift stage and the instruction it updates
  always_comb begin
    ir_sh_d = ir_sh_q;
    ir_d    = ir_q;
    if (cap_ir) begin
      ir_sh_d = `SBST_IR_CAPTURE;
    end else if (shift_ir) begin
      ir_sh_d = {tdi_s, ir_sh_q[IR_W-1:1]};
    end
    if (in_reset) begin
      ir_d = `SBST_IR_IDCODE;
    end else if (upd_ir) begin
      ir_d = ir_sh_q;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ir_sh_q <= `SBST_IR_CAPTURE;
      ir_q    <= `SBST_IR_IDCODE;
    end else begin
      ir_sh_q <= ir_sh_d;
      ir_q    <= ir_d;
    end
  end

  // Bypass stage
  always_comb begin
    byp_d = byp_q;
    if (cap_dr && sel_byp) begin
      byp_d = `SBST_BYPASS_CAP;
    end else if (shift_dr && sel_byp) begin
      byp_d = tdi_s;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      byp_q <= 1'b0;
    end else begin
      byp_q <= byp_d;
    end
  end

  // Identification stage
  always_comb begin
    id_d = id_q;
    if (cap_dr && sel_id) begin
      id_d = ID_CODE;
    end else if (shift_dr && sel_id) begin
      id_d = {tdi_s, id_q[ID_W-1:1]};
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      id_q <= '0;
    end else begin
      id_q <= id_d;
    end
  end

  // Boundary shift stage and its update latches
  always_comb begin
    bsr_d = bsr_q;
    upd_d = upd_q;
    if (cap_dr && sel_bsr) begin
      // Unconnected package positions capture low
      bsr_d = {{NC_CELLS{1'b0}}, ring_s};
    end else if (shift_dr && sel_bsr) begin
      bsr_d = {tdi_s, bsr_q[BSR_LEN-1:1]};
    end
    if (in_reset) begin
      upd_d = UPD_RST;
    end else if (upd_dr && (extest || (ir_q == `SBST_IR_SAMPLE))) begin
      upd_d = bsr_q;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bsr_q <= '0;
      upd_q <= UPD_RST;
    end else begin
      bsr_q <= bsr_d;
      upd_q <= upd_d;
    end
  end

  // Serial output enable; driven only while a register is being shifted
  always_comb begin
    tdo_oe_d = tdo_oe_q;
    if (tck_fall) begin
      tdo_oe_d = (state == sbst_pkg::SBST_SHIFT_IR) ||
                 (state == sbst_pkg::SBST_SHIFT_DR);
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_oe_q <= tdo_oe_d;
    end
  end

  // Serial output value, taken from the stage in the scan path
  always_comb begin
    tdo_d = tdo_q;
    if (tck_fall) begin
      tdo_d = (state == sbst_pkg::SBST_SHIFT_IR) ? ir_sh_q[0]
                                                 : dr_lsb;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tdo_q <= 1'b0;
    end else begin
      tdo_q <= tdo_d;
    end
  end

  // Output-bus control toward the memory; outside external test and
  // sample-high-Z the memory keeps its own enable, so a test reset
  // never reaches the memory core.
  logic q_oe_q;
  logic q_oe_d;
  logic extest_q;
  logic extest_d;

  always_comb begin
    if (sample_z) begin
      q_oe_d = 1'b0;
    end else if (extest) begin
      q_oe_d = upd_q[OE_CELL];
    end else begin
      q_oe_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      q_oe_q <= 1'b1;
    end else begin
      q_oe_q <= q_oe_d;
    end
  end

  // Registered like the enable so both reach the memory in one cycle
  always_comb begin
    extest_d = extest;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      extest_q <= 1'b0;
    end else begin
      extest_q <= extest_d;
    end
  end

  assign tdo_o       = tdo_q;
  assign tdo_oe_o    = tdo_oe_q;
  assign bsr_pdata_o = upd_q;
  assign extest_o    = extest_q;
  assign q_oe_o      = q_oe_q;

endmodule

// >>> tb/sbst_tap_properties.sv
module sbst_tap_props #(
  parameter int FUNC_PINS = 101,
  parameter int NC_CELLS  = 8
) (
  input wire logic                          ref_clk_i,
  input wire logic                          sys_rst_i,
  input wire logic                          tck_i,
  input wire logic                          tms_i,
  input wire logic                          tdi_i,
  input wire logic [FUNC_PINS-1:0]          ring_i,
  input wire logic                          tdo_o,
  input wire logic                          tdo_oe_o,
  input wire logic [FUNC_PINS+NC_CELLS-1:0] bsr_pdata_o,
  input wire logic                          extest_o,
  input wire logic                          q_oe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [FUNC_PINS+NC_CELLS-1:0] P47 =
    {{(FUNC_PINS+NC_CELLS-1){1'b0}}, 1'b1} << 47;
  logic       tck_q;
  logic [2:0] hi_cnt_q;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // Counts test clock rises seen with mode select high
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tck_q    <= 1'b0;
      hi_cnt_q <= 3'h0;
    end else begin
      tck_q <= tck_i;
      if (tck_i && !tck_q) begin
        hi_cnt_q <= !tms_i ? 3'h0
                  : (hi_cnt_q == 3'h5 ? 3'h5 : hi_cnt_q + 3'h1);
      end
    end
  end

  sequence s_ext_steady;
    (extest_o && $stable(bsr_pdata_o)) [*2];
  endsequence
  sequence s_fifth_high;
    hi_cnt_q == 3'h4 && tck_i && !tck_q && tms_i;
  endsequence

  a_tdo_fall_only:
    assert property ($changed(tdo_o) |-> !$past(tck_i, 2))
    else $error("tdo moved while test clock high");
  a_oe_fall_only:
    assert property ($changed(tdo_oe_o) |-> !$past(tck_i, 2))
    else $error("tdo enable moved while test clock high");
  a_ext_cell_drive:
    assert property (s_ext_steady |-> q_oe_o == bsr_pdata_o[47])
    else $error("output enable does not follow cell 47");
  a_five_high_reset:
    assert property (s_fifth_high |-> ##[1:12]
                     (!extest_o && bsr_pdata_o == P47 && q_oe_o))
    else $error("five high mode selects did not reset");
  a_powerup_quiet:
    assert property ($fell(sys_rst_i) |-> !tdo_oe_o && !extest_o && q_oe_o)
    else $error("port not quiet after power-up");
  a_qoe_on_update:
    assert property ($changed(q_oe_o) |-> !tdo_oe_o)
    else $error("output enable moved during shifting");
  a_ir_on_update:
    assert property ($changed(extest_o) |-> !tdo_oe_o)
    else $error("instruction changed during shifting");
  a_preload_update:
    assert property ($changed(bsr_pdata_o) |-> !tdo_oe_o)
    else $error("preload changed during shifting");
endmodule

bind sbst_tap sbst_tap_props #(
  .FUNC_PINS(FUNC_PINS),
  .NC_CELLS (NC_CELLS)
) i_sbst_tap_props (
  .ref_clk_i, .sys_rst_i, .tck_i, .tms_i, .tdi_i, .ring_i,
  .tdo_o, .tdo_oe_o, .bsr_pdata_o, .extest_o, .q_oe_o
);

// >>> tb/sbst_ctl_model.sv
module sbst_ctl_model (
  input  wire logic ref_clk_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    tck_o = 1'b0; // Clock stands low between frames
    tms_o = 1'b1; // Floating inputs resolve high
    tdi_o = 1'b1;
  end

  // One 80 ns test clock period; tdo taken just before the rise
  task automatic step(input logic ms, input logic di, output logic dout);
    @(negedge ref_clk_i);
    tms_o = ms;
    tdi_o = di;
    repeat (3) @(negedge ref_clk_i);
    dout = tdo_oe_i ? tdo_i : 1'bz;
    tck_o = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    tck_o = 1'b0;
  endtask

  task automatic scan(input logic ir, input int n,
                      input logic [127:0] din, output logic [127:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b1, b);
    if (ir) begin
      step(1'b1, 1'b1, b);
    end
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b1, b); // Pass through update
    step(1'b0, 1'b1, b);
  endtask

  task automatic tap_reset();
    logic b;
    repeat (5) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
endmodule

// >>> tb/test_sbst_tap.sv
module test_sbst_tap;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int FP = 101;
  localparam int BW = 109;
  // Arbitrary identification value
  localparam logic [31:0] ID = 32'h1234_5679;
  localparam logic [BW-1:0] P47 = 109'h1 << 47;

  logic          ref_clk_i = 1'b0;
  logic          sys_rst_i = 1'b1;
  logic          tck, tms, tdi, tdo, tdo_oe, extest, q_oe;
  logic [FP-1:0] ring = '0;
  logic [BW-1:0] pdata;
  int            n_fail = 0;
  int            total_checks = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  sbst_tap #(.FUNC_PINS(FP), .NC_CELLS(8), .ID_CODE(ID)) i_sbst_tap (
    .ref_clk_i  (ref_clk_i),
    .sys_rst_i  (sys_rst_i),
    .tck_i      (tck),
    .tms_i      (tms),
    .tdi_i      (tdi),
    .ring_i     (ring),
    .tdo_o      (tdo),
    .tdo_oe_o   (tdo_oe),
    .bsr_pdata_o(pdata),
    .extest_o   (extest),
    .q_oe_o     (q_oe)
  );

  sbst_ctl_model u_ctl (
    .ref_clk_i(ref_clk_i),
    .tdo_i    (tdo),
    .tdo_oe_i (tdo_oe),
    .tck_o    (tck),
    .tms_o    (tms),
    .tdi_o    (tdi)
  );

  task automatic check(input string what, input logic [127:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic t_idle_state();
    check("tdo_oe", tdo_oe, 1'b0);
    check("q_oe", q_oe, 1'b1);
    check("extest", extest, 1'b0);
    check("pdata", pdata, P47);
  endtask

  task automatic t_idcode();
    logic [127:0] d;
    u_ctl.scan(1'b0, 32, '1, d);
    check("idcode", d[31:0], ID);
    check("tdo_oe idle", tdo_oe, 1'b0);
  endtask

  // Bypass and the reserved codes: one-bit path that captures low
  task automatic t_bypass();
    logic [2:0]   codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
    logic [7:0]   pat = 8'hb5;
    logic [127:0] d;
    foreach (codes[k]) begin
      u_ctl.scan(1'b1, 3, 128'(codes[k]), d);
      check("ir capture", d[2:0], 3'h1);
      u_ctl.scan(1'b0, 8, 128'(pat), d);
      check("bypass", d[7:0], {pat[6:0], 1'b0});
    end
  endtask

  // Pin ring capture, preload and output control per instruction
  task automatic t_ring();
    logic [2:0]    codes [3] = '{3'h2, 3'h4, 3'h0};
    logic [BW-1:0] din;
    logic [BW-1:0] pre;
    logic [127:0]  d;
    din = BW'({4{32'hc3a5_96e1}});
    din[47] = 1'b0;
    pre = P47;
    foreach (codes[k]) begin
      @(negedge ref_clk_i);
      ring = FP'({4{32'h1e2d_3c4b}}) ^ FP'(k + 1);
      u_ctl.scan(1'b1, 3, 128'(codes[k]), d);
      check("q_oe", q_oe, codes[k] == 3'h4);
      check("extest", extest, codes[k] == 3'h0);
      u_ctl.scan(1'b0, BW, 128'(din), d);
      check("ring", d[BW-1:0], {8'h00, ring});
      // Sample-high-Z leaves the update latches as they were
      if (codes[k] != 3'h2) begin
        pre = din;
      end
      check("preload", pdata, pre);
      if (codes[k] == 3'h0) begin
        check("q_oe cell", q_oe, 1'b1);
      end
      din = ~din;
      // Only the external-test pass loads an enabling cell 47
      din[47] = (k == 1);
    end
  endtask

  task automatic t_tap_reset();
    u_ctl.tap_reset();
    t_idle_state();
    t_idcode();
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk_i);
    n_fail++;
    final_report();
  end

  initial begin
    logic b;
    repeat (12) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    t_idle_state();
    // Scans start from run-test-idle; leave the reset state first
    u_ctl.step(1'b0, 1'b1, b);
    t_idcode();
    t_bypass();
    t_ring();
    t_tap_reset();
    final_report();
  end
endmodule
